/* File: hw/pmon_regs.sv */
// Register bank of the current and power monitor, pointer addressed.
// Assumes a serial front end delivering pointer, write and read bytes
// as one-cycle strobes, and a converter delivering results.
// Function
// - Configuration at 00, resets 399F
// - Read-only status at 01, resets 0000
// - Alert mask at 02, resets 0000
// - Shunt, bus, power results at 03-05
// - Current at 06, zero while calibration zero
// - Positive shunt peak at 07, resets 8000
// - Negative shunt peak at 08, resets 7FFF
// - Bus maximum peak at 09, resets 0000
// - Bus minimum peak at 0A, resets FFF8
// - Power peak at 0B, resets 0000
// - Shunt above 0C raises warning flag, pin
// - Shunt below 0D raises warning flag, pin
// - Power above 0E raises warning flag, pin
// - 0F holds bus high warning, pin control
// - Bus below 10 raises warning flag, pin
// - Power above 11 raises over-limit flag, pin
// - 12 holds bus over-limit, pin control
// - Bus below 13 raises over-limit flag, pin
// - 14 holds critical positive limit, controls
// - 15 holds critical negative limit, latch from 14
// - Calibration at 16, resets 0000
// - Sixteen-bit registers moved as two bytes
// - Writes take effect 4 us later
// - Status read clears, live limits reset flags
// - Configuration bit 15 resets whole bank
`timescale 1ns/100ps
module pmon_regs (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ptr_wr_in,
  input wire logic data_wr_in,
  input wire logic [7:0] wr_byte_in,
  input wire logic rd_req_in,
  output logic [7:0] rd_byte_out,
  input wire logic meas_valid_in,
  input wire logic [15:0] shunt_in,
  input wire logic [15:0] bus_in,
  input wire logic [15:0] power_in,
  input wire logic [15:0] current_in,
  input wire logic overflow_in,
  output logic [15:0] cfg_out,
  output logic [15:0] cal_out,
  output logic warn_pin_out,
  output logic overlimit_pin_out
);
  logic [7:0] ptr;
  logic wr_phase;
  logic [7:0] wr_msb;
  logic pend_valid;
  logic [7:0] pend_addr;
  logic [15:0] pend_data;
  logic [7:0] pend_cnt;
  logic commit;
  logic soft_rst;
  logic rst_all;
  logic rd_phase;
  logic [7:0] rd_shadow;
  logic [15:0] read_word;
  logic status_clr;
  logic [15:0] cfg_q;
  logic [15:0] mask_q;
  logic [15:0] status_q;
  logic [15:0] shunt_q;
  logic [15:0] bus_q;
  logic [15:0] power_q;
  logic [15:0] cur_q;
  localparam int LIM_FIRST = pmon_pkg::LIM_FIRST;
  localparam int LIM_LAST = pmon_pkg::LIM_LAST;
  logic [15:0] lim_q [LIM_FIRST:LIM_LAST];
  logic [15:0] pk [pmon_pkg::NUM_PEAK];
  logic [15:0] src_now [3];
  logic [15:0] src_res [3];
  logic [pmon_pkg::NUM_CMP-1:0] trip;
  logic warn_active;
  logic ol_active;

  // Write completes on the second byte, then waits out the update delay
  assign commit = pend_valid && (pend_cnt == 8'h00);
  assign soft_rst = commit && (pend_addr == pmon_pkg::PTR_CFG)
                    && pend_data[pmon_pkg::CFG_RST_BIT];
  assign rst_all = rst_in || soft_rst;
  assign status_clr = rd_req_in && !rd_phase && !ptr_wr_in
                      && (ptr == pmon_pkg::PTR_STATUS);
  assign cfg_out = cfg_q;
  assign cal_out = lim_q[LIM_LAST];

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      ptr <= 8'h00;
    else if (ptr_wr_in)
      ptr <= wr_byte_in;
  end

  // Byte pairing: first data byte is the high half
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      wr_phase <= 1'b0;
      wr_msb <= 8'h00;
    end
    else if (ptr_wr_in)
      wr_phase <= 1'b0;
    else if (data_wr_in)
    begin
      wr_phase <= !wr_phase;
      if (!wr_phase)
        wr_msb <= wr_byte_in;
    end
  end

  // A newer write replaces one still waiting; the older one is lost
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      pend_valid <= 1'b0;
      pend_addr <= 8'h00;
      pend_data <= 16'h0000;
      pend_cnt <= 8'h00;
    end
    else if (data_wr_in && wr_phase && !ptr_wr_in)
    begin
      pend_valid <= 1'b1;
      pend_addr <= ptr;
      pend_data <= {wr_msb, wr_byte_in};
      pend_cnt <= pmon_pkg::WR_DLY_LOAD;
    end
    else if (commit)
      pend_valid <= 1'b0;
    else if (pend_valid)
      pend_cnt <= pend_cnt - 8'h01;
  end

  // Reset bit is never stored, so it reads back as zero
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      cfg_q <= pmon_pkg::CFG_RESET;
    else if (commit && pend_addr == pmon_pkg::PTR_CFG)
      cfg_q <= pend_data & 16'h7FFF;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      mask_q <= pmon_pkg::ZERO_RESET;
    else if (commit && pend_addr == pmon_pkg::PTR_MASK)
      mask_q <= pend_data;
  end

  // Limit and calibration words, pointers 0C to 16
  generate
    for (genvar k = LIM_FIRST; k <= LIM_LAST; k++)
    begin : g_lim
      always_ff @(posedge core_clk_in)
      begin
        if (rst_all)
          lim_q[k] <= pmon_pkg::ZERO_RESET;
        else if (commit && pend_addr == 8'(k))
          lim_q[k] <= pend_data;
      end
    end
  endgenerate

  // Results; current held at zero until calibrated
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      shunt_q <= pmon_pkg::ZERO_RESET;
      bus_q <= pmon_pkg::ZERO_RESET;
      power_q <= pmon_pkg::ZERO_RESET;
      cur_q <= pmon_pkg::ZERO_RESET;
    end
    else if (meas_valid_in)
    begin
      shunt_q <= shunt_in;
      bus_q <= bus_in;
      power_q <= power_in;
      cur_q <= (lim_q[LIM_LAST] == 16'h0000) ? 16'h0000 : current_in;
    end
  end

  assign src_now[pmon_pkg::SRC_SHUNT] = shunt_in;
  assign src_now[pmon_pkg::SRC_BUS] = bus_in;
  assign src_now[pmon_pkg::SRC_POWER] = power_in;
  assign src_res[pmon_pkg::SRC_SHUNT] = shunt_q;
  assign src_res[pmon_pkg::SRC_BUS] = bus_q;
  assign src_res[pmon_pkg::SRC_POWER] = power_q;

  generate
    for (genvar j = 0; j < pmon_pkg::NUM_PEAK; j++)
    begin : g_peak
      pmon_peak #(
        .RESET_VAL(pmon_pkg::PK_RESET[j]),
        .IS_SIGNED(pmon_pkg::PK_SIGNED[j]),
        .FIND_MAX(pmon_pkg::PK_MAX[j])
      ) u_peak (
        .core_clk_in(core_clk_in),
        .rst_in(rst_all),
        .sample_valid_in(meas_valid_in),
        .sample_in(src_now[pmon_pkg::PK_SRC[j]]),
        .load_in(commit && pend_addr == 8'(pmon_pkg::PEAK_FIRST + j)),
        .load_data_in(pend_data),
        .peak_out(pk[j])
      );
    end
  endgenerate

  // Watchdog flags; control bits in the 0F and 12 limit words are masked off
  generate
    for (genvar i = 0; i < pmon_pkg::NUM_CMP; i++)
    begin : g_cmp
      localparam int LP = pmon_pkg::CMP_LIM[i];
      localparam int BIT = pmon_pkg::ST_FIRST_CMP - i;
      localparam bit CTRL = (LP == 15) || (LP == 18);
      pmon_cmp #(
        .IS_SIGNED(pmon_pkg::CMP_SIGNED[i]),
        .ABOVE(pmon_pkg::CMP_ABOVE[i])
      ) u_cmp (
        .value_in(src_res[pmon_pkg::CMP_SRC[i]]),
        .limit_in(CTRL ? (lim_q[LP] & pmon_pkg::CTRL_LIM_MASK) : lim_q[LP]),
        .trip_out(trip[i])
      );
      // Trip wins over clear; unlatched flags just follow the limit
      always_ff @(posedge core_clk_in)
      begin
        if (rst_all)
          status_q[BIT] <= 1'b0;
        else if (trip[i])
          status_q[BIT] <= 1'b1;
        else if (!lim_q[pmon_pkg::CMP_LATCH[i]][pmon_pkg::LATCH_BIT])
          status_q[BIT] <= 1'b0;
        else if (status_clr)
          status_q[BIT] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      status_q[pmon_pkg::ST_CNVR:0] <= 6'h00;
    end
    else
    begin
      status_q[2:0] <= 3'h0;
      if (meas_valid_in)
        status_q[pmon_pkg::ST_CNVR] <= 1'b1;
      else if (status_clr)
        status_q[pmon_pkg::ST_CNVR] <= 1'b0;
      if (|(status_q[15:5] & mask_q[15:5]))
        status_q[pmon_pkg::ST_ALERT] <= 1'b1;
      else if (status_clr)
        status_q[pmon_pkg::ST_ALERT] <= 1'b0;
      if (overflow_in)
        status_q[pmon_pkg::ST_OVF] <= 1'b1;
      else if (status_clr)
        status_q[pmon_pkg::ST_OVF] <= 1'b0;
    end
  end

  // Pin polarity bit clear means active low
  assign warn_active = |status_q[15:pmon_pkg::ST_WARN_LO];
  assign ol_active = |status_q[pmon_pkg::ST_OL_HI:pmon_pkg::ST_OL_LO];

  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      warn_pin_out <= 1'b1;
      overlimit_pin_out <= 1'b1;
    end
    else
    begin
      warn_pin_out <= warn_active ~^
        lim_q[LIM_FIRST + 3][pmon_pkg::POL_BIT];
      overlimit_pin_out <= ol_active ~^
        lim_q[LIM_FIRST + 6][pmon_pkg::POL_BIT];
    end
  end

  always_comb
  begin
    read_word = 16'h0000;
    if (ptr == pmon_pkg::PTR_CFG)
      read_word = cfg_q;
    else if (ptr == pmon_pkg::PTR_STATUS)
      read_word = status_q;
    else if (ptr == pmon_pkg::PTR_MASK)
      read_word = mask_q;
    else if (ptr == pmon_pkg::PTR_SHUNT)
      read_word = shunt_q;
    else if (ptr == pmon_pkg::PTR_BUS)
      read_word = bus_q;
    else if (ptr == pmon_pkg::PTR_POWER)
      read_word = power_q;
    else if (ptr == pmon_pkg::PTR_CURRENT)
      read_word = cur_q;
    else if (ptr >= pmon_pkg::PTR_PEAK_FIRST && ptr <= pmon_pkg::PTR_PEAK_LAST)
      read_word = pk[3'(ptr - pmon_pkg::PTR_PEAK_FIRST)];
    else if (ptr >= pmon_pkg::PTR_LIM_FIRST && ptr <= pmon_pkg::PTR_CAL)
      read_word = lim_q[5'(ptr)];
  end

  // Low byte is frozen at the high-byte read so both halves agree
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
    begin
      rd_phase <= 1'b0;
      rd_shadow <= 8'h00;
      rd_byte_out <= 8'h00;
    end
    else if (ptr_wr_in)
      rd_phase <= 1'b0;
    else if (rd_req_in)
    begin
      rd_phase <= !rd_phase;
      if (!rd_phase)
      begin
        rd_byte_out <= read_word[15:8];
        rd_shadow <= read_word[7:0];
      end
      else
        rd_byte_out <= rd_shadow;
    end
  end

  // Cycles since the last completed write, for the delay check
  logic [7:0] since_wr;
  always_ff @(posedge core_clk_in)
  begin
    if (rst_all)
      since_wr <= 8'hFF;
    else if (data_wr_in && wr_phase && !ptr_wr_in)
      since_wr <= 8'h00;
    else if (since_wr != 8'hFF)
      since_wr <= since_wr + 8'h01;
  end

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  cfg_reset_a: assert property (disable iff (1'b0)
    rst_in |=> cfg_q == 16'h399F) else $error("config reset value wrong");
  mask_write_a: assert property (
    commit && pend_addr == 8'h02 && !soft_rst |=> mask_q == $past(pend_data))
    else $error("mask write lost");
  write_delay_a: assert property (
    commit |-> since_wr == 8'h27) else $error("write delay not 40 cycles");
  status_clear_a: assert property (
    status_clr && !trip[3] && !soft_rst |=> !status_q[12])
    else $error("status flag not cleared by read");
  current_zero_a: assert property (
    meas_valid_in && lim_q[22] == 16'h0000 |=> cur_q == 16'h0000)
    else $error("current nonzero while uncalibrated");
  pos_peak_a: assert property (
    meas_valid_in && !commit && $signed(shunt_in) > $signed(pk[0])
    |=> pk[0] == $past(shunt_in)) else $error("positive peak missed");
  bus_min_a: assert property (
    meas_valid_in && !commit |=> pk[3] <= $past(bus_in))
    else $error("bus minimum peak above sample");
  warn_pin_a: assert property (
    trip[3] && !commit ##1 !commit
    |=> warn_pin_out == lim_q[15][1]) else $error("warning pin not active");
  ol_pin_a: assert property (
    trip[7] && !commit ##1 !commit
    |=> overlimit_pin_out == lim_q[18][1]) else $error("over-limit pin idle");
  soft_reset_a: assert property (
    soft_rst |=> cfg_q == 16'h399F && pk[1] == 16'h7FFF && lim_q[22] == 0)
    else $error("soft reset incomplete");
  byte_pair_a: assert property (
    rd_req_in && rd_phase && !ptr_wr_in && !soft_rst
    |=> rd_byte_out == $past(rd_shadow)) else $error("low byte mismatch");

  commit_c: cover property (commit && pend_addr == 8'h16);
  status_read_c: cover property (status_clr && status_q[12]);
  soft_reset_c: cover property (soft_rst);
endmodule : pmon_regs

/* File: hw/pmon_pkg.sv */
// Constants for the power monitor register bank.
// Assumes a 10 MHz core clock and byte-wide pointer access from a serial
// front end that is not part of this package.
package pmon_pkg;
  localparam logic [7:0] PTR_CFG = 8'h00;
  localparam logic [7:0] PTR_STATUS = 8'h01;
  localparam logic [7:0] PTR_MASK = 8'h02;
  localparam logic [7:0] PTR_SHUNT = 8'h03;
  localparam logic [7:0] PTR_BUS = 8'h04;
  localparam logic [7:0] PTR_POWER = 8'h05;
  localparam logic [7:0] PTR_CURRENT = 8'h06;
  localparam logic [7:0] PTR_PEAK_FIRST = 8'h07;
  localparam logic [7:0] PTR_PEAK_LAST = 8'h0B;
  localparam logic [7:0] PTR_LIM_FIRST = 8'h0C;
  localparam logic [7:0] PTR_BUS_HIGH_WARN = 8'h0F;
  localparam logic [7:0] PTR_BUS_HIGH_OL = 8'h12;
  localparam logic [7:0] PTR_CRIT_POS = 8'h14;
  localparam logic [7:0] PTR_CAL = 8'h16;
  localparam int LIM_FIRST = 12;
  localparam int LIM_LAST = 22;
  localparam int PEAK_FIRST = 7;

  localparam logic [15:0] CFG_RESET = 16'h399F;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam int CFG_RST_BIT = 15;
  // Control bits in the low end of the 0F, 12 and 14 limit words
  localparam int LATCH_BIT = 0;
  localparam int POL_BIT = 1;
  localparam logic [15:0] CTRL_LIM_MASK = 16'hFFFC;

  localparam int ST_CNVR = 5;
  localparam int ST_ALERT = 4;
  localparam int ST_OVF = 3;
  localparam int ST_FIRST_CMP = 15;
  localparam int ST_WARN_LO = 11;
  localparam int ST_OL_HI = 10;
  localparam int ST_OL_LO = 8;
  localparam int ST_CRIT_LO = 6;

  // Comparator table, entry i drives status bit 15-i
  localparam int NUM_CMP = 10;
  localparam int SRC_SHUNT = 0;
  localparam int SRC_BUS = 1;
  localparam int SRC_POWER = 2;
  localparam int CMP_SRC [NUM_CMP] = '{1, 1, 2, 0, 0, 1, 1, 2, 0, 0};
  localparam int CMP_LIM [NUM_CMP] = '{15, 16, 14, 12, 13, 18, 19, 17, 20, 21};
  localparam int CMP_LATCH [NUM_CMP] = '{15, 15, 15, 15, 15, 18, 18, 18, 20, 20};
  localparam bit CMP_ABOVE [NUM_CMP] = '{1, 0, 1, 1, 0, 1, 0, 1, 1, 0};
  localparam bit CMP_SIGNED [NUM_CMP] = '{0, 0, 0, 1, 1, 0, 0, 0, 1, 1};

  // Peak trackers, entry j sits at pointer 07+j
  localparam int NUM_PEAK = 5;
  localparam logic [15:0] PK_RESET [NUM_PEAK] =
    '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFF8, 16'h0000};
  localparam int PK_SRC [NUM_PEAK] = '{0, 0, 1, 1, 2};
  localparam bit PK_MAX [NUM_PEAK] = '{1, 0, 1, 0, 1};
  localparam bit PK_SIGNED [NUM_PEAK] = '{1, 1, 0, 0, 0};

  localparam int CLK_PERIOD_NS = 100;
  localparam int WRITE_DELAY_NS = 4000;
  localparam int WRITE_DELAY_CYCLES =
    (WRITE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] WR_DLY_LOAD = 8'(WRITE_DELAY_CYCLES - 1);
endpackage : pmon_pkg

/* File: hw/pmon_peak.sv */
// One peak tracker: keeps the most extreme sample seen.
// Assumes samples arrive with a one-cycle valid strobe.
`timescale 1ns/100ps
module pmon_peak #(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter bit IS_SIGNED = 1'b0,
  parameter bit FIND_MAX = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic sample_valid_in,
  input wire logic [15:0] sample_in,
  input wire logic load_in,
  input wire logic [15:0] load_data_in,
  output logic [15:0] peak_out
);
  logic gt;
  logic lt;
  logic more;

  assign gt = IS_SIGNED ? ($signed(sample_in) > $signed(peak_out))
                        : (sample_in > peak_out);
  assign lt = IS_SIGNED ? ($signed(sample_in) < $signed(peak_out))
                        : (sample_in < peak_out);
  assign more = FIND_MAX ? gt : lt;

  always_ff @(posedge core_clk_in)
  begin
    if (rst_in)
      peak_out <= RESET_VAL;
    else if (load_in)
      peak_out <= load_data_in;
    else if (sample_valid_in && more)
      peak_out <= sample_in;
  end
endmodule : pmon_peak

/* File: hw/pmon_cmp.sv */
// Limit comparator for one watchdog threshold.
// Assumes value and limit share the same scale.
`timescale 1ns/100ps
module pmon_cmp #(
  parameter bit IS_SIGNED = 1'b0,
  parameter bit ABOVE = 1'b1
) (
  input wire logic [15:0] value_in,
  input wire logic [15:0] limit_in,
  output logic trip_out
);
  logic gt;
  logic lt;

  assign gt = IS_SIGNED ? ($signed(value_in) > $signed(limit_in))
                        : (value_in > limit_in);
  assign lt = IS_SIGNED ? ($signed(value_in) < $signed(limit_in))
                        : (value_in < limit_in);
  assign trip_out = ABOVE ? gt : lt;
endmodule : pmon_cmp

/* File: testbench/pmon_host_model.sv */
// Host side model: pointer, word write and word read on the byte port.
// Assumes the bench pops exp_q as each read byte comes back.
`timescale 1ns/100ps
module pmon_host_model (
  input wire logic core_clk_in,
  output logic ptr_wr_out,
  output logic data_wr_out,
  output logic [7:0] wr_byte_out,
  output logic rd_req_out
);
  logic [7:0] exp_q [$];

  initial
  begin
    ptr_wr_out = 1'b0;
    data_wr_out = 1'b0;
    wr_byte_out = 8'h00;
    rd_req_out = 1'b0;
  end

  task automatic drv(logic p, logic d, logic r, logic [7:0] b);
    @(posedge core_clk_in);
    ptr_wr_out <= p;
    data_wr_out <= d;
    rd_req_out <= r;
    wr_byte_out <= b;
  endtask : drv

  // Released byte lines toggle so a stale byte is never trusted
  task automatic idle(int n);
    repeat (n) drv(1'b0, 1'b0, 1'b0, ~wr_byte_out);
  endtask : idle

  task automatic write_word(logic [7:0] p, logic [15:0] v, int n);
    drv(1'b1, 1'b0, 1'b0, p);
    drv(1'b0, 1'b1, 1'b0, v[15:8]);
    drv(1'b0, 1'b1, 1'b0, v[7:0]);
    idle(n); // Caller picks the settle time
  endtask : write_word

  task automatic read_word(logic [7:0] p, logic [15:0] e);
    drv(1'b1, 1'b0, 1'b0, p);
    exp_q.push_back(e[15:8]);
    drv(1'b0, 1'b0, 1'b1, ~p);
    exp_q.push_back(e[7:0]);
    drv(1'b0, 1'b0, 1'b1, ~p);
    idle(1);
  endtask : read_word
endmodule : pmon_host_model

/* File: testbench/power_monitor_register_map_tb_top.sv */
// Bench top: host model on the byte port, converter results from the bench.
// Assumes read bytes appear the cycle after each read request.
`timescale 1ns/100ps
module power_monitor_register_map_tb_top;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ptr_wr, data_wr, rd_req, warn_pin, ol_pin, rd_q;
  logic meas_valid = 1'b0;
  logic overflow = 1'b0;
  logic [7:0] wr_byte, rd_byte, eb;
  logic [15:0] shunt = 16'h0000, bus = 16'h0000;
  logic [15:0] power = 16'h0000, current = 16'h0000;
  logic [15:0] cfg, cal, v, c, m;
  logic [15:0] pk [5] = '{16'h8000, 16'h7FFF, 16'h0000, 16'hFFF8, 16'h0000};
  logic [31:0] seed = 32'h89F33873;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;

  always #50 core_clk_in = ~core_clk_in;

  pmon_regs i_pmon_regs (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ptr_wr_in(ptr_wr),
    .data_wr_in(data_wr), .wr_byte_in(wr_byte), .rd_req_in(rd_req),
    .rd_byte_out(rd_byte), .meas_valid_in(meas_valid), .shunt_in(shunt),
    .bus_in(bus), .power_in(power), .current_in(current),
    .overflow_in(overflow), .cfg_out(cfg), .cal_out(cal),
    .warn_pin_out(warn_pin), .overlimit_pin_out(ol_pin));

  pmon_host_model i_pmon_host_model (
    .core_clk_in(core_clk_in), .ptr_wr_out(ptr_wr), .data_wr_out(data_wr),
    .wr_byte_out(wr_byte), .rd_req_out(rd_req));

  function automatic logic [15:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0];
  endfunction : rnd

  function automatic logic [15:0] pick(logic [15:0] a, logic [15:0] b,
    logic hi, logic sg);
    logic gt;
    gt = sg ? ($signed(b) > $signed(a)) : (b > a);
    return (gt == hi) ? b : a;
  endfunction : pick

  task automatic compare(string nm, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : compare

  task automatic conclude();
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  task automatic rd(logic [7:0] p, logic [15:0] e);
    i_pmon_host_model.read_word(p, e);
  endtask : rd

  task automatic wr(logic [7:0] p, logic [15:0] e, int n);
    i_pmon_host_model.write_word(p, e, n);
  endtask : wr

  task automatic pins(logic [15:0] e);
    i_pmon_host_model.idle(4);
    @(negedge core_clk_in);
    compare("pins", e, {14'h0, warn_pin, ol_pin});
  endtask : pins

  task automatic sample(logic [15:0] s, logic [15:0] b, logic [15:0] p,
    logic [15:0] cu);
    @(posedge core_clk_in);
    meas_valid <= 1'b1;
    shunt <= s;
    bus <= b;
    power <= p;
    current <= cu;
    @(posedge core_clk_in);
    meas_valid <= 1'b0;
    overflow <= 1'b0;
    pk[0] = pick(pk[0], s, 1'b1, 1'b1);
    pk[1] = pick(pk[1], s, 1'b0, 1'b1);
    pk[2] = pick(pk[2], b, 1'b1, 1'b0);
    pk[3] = pick(pk[3], b, 1'b0, 1'b0);
    pk[4] = pick(pk[4], p, 1'b1, 1'b0);
  endtask : sample

  // Read byte checker, one queued note per returned byte
  always @(posedge core_clk_in) rd_q <= rd_req;
  always @(negedge core_clk_in)
  begin
    if (rd_q === 1'b1)
    begin
      if (i_pmon_host_model.exp_q.size() == 0)
        compare("read queue", 16'h0000, 16'h0001);
      else
      begin
        eb = i_pmon_host_model.exp_q.pop_front();
        compare("rd_byte_out", {8'h00, eb}, {8'h00, rd_byte});
      end
    end
  end

  // Whole run needs under two thousand cycles
  always @(posedge core_clk_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end

  initial
  begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    @(negedge core_clk_in);
    compare("cfg_out", 16'h399F, cfg);
    compare("cal_out", 16'h0000, cal);
    compare("pins", 16'h0003, {14'h0, warn_pin, ol_pin});
    for (int i = 0; i < 24; i++)
    begin
      v = (i == 0) ? 16'h399F : 16'h0000;
      if (i >= 7 && i <= 11)
        v = pk[i - 7];
      rd(8'(i), v);
    end
    sample(rnd(), rnd(), rnd(), rnd() | 16'h0001);
    rd(8'h03, shunt);
    rd(8'h04, bus);
    rd(8'h05, power);
    rd(8'h06, 16'h0000);
    sample(rnd(), rnd(), rnd(), rnd());
    v = rnd();
    wr(8'h0B, v, 41);
    pk[4] = v;
    for (int j = 0; j < 5; j++)
      rd(8'(7 + j), pk[j]);
    wr(8'h16, rnd() | 16'h0001, 41);
    sample(rnd(), rnd(), rnd(), rnd());
    rd(8'h06, current);
    for (int p = 0; p < 23; p++)
    begin
      if (p == 1 || p == 4 || p == 5)
        continue;
      v = rnd();
      v[15] = (p == 0) ? 1'b0 : v[15];
      wr(8'(p), v, 41);
      c = (p == 0) ? v : c;
      m = (p == 2) ? v : m;
      v = (p == 3) ? shunt : ((p == 6) ? current : v);
      rd(8'(p), v);
    end
    @(negedge core_clk_in);
    compare("cfg_out", c, cfg);
    compare("cal_out", v, cal);
    wr(8'h02, 16'hA5C3, 30);
    rd(8'h02, m);
    i_pmon_host_model.idle(10);
    rd(8'h02, 16'hA5C3);
    wr(8'h00, 16'h8000, 41);
    // Commit lands on the edge the write task returns at
    @(negedge core_clk_in);
    compare("cfg_out", 16'h399F, cfg);
    compare("cal_out", 16'h0000, cal);
    rd(8'h02, 16'h0000);
    rd(8'h07, 16'h8000);
    // Bus high warning out of reach, warning pin active high
    wr(8'h0F, 16'hFFFE, 41);
    wr(8'h0C, 16'h0100, 41);
    wr(8'h02, 16'h1000, 41);
    overflow <= 1'b1;
    sample(16'h0200, 16'h1000, 16'h0000, 16'h0000);
    pins(16'h0002);
    rd(8'h01, 16'h14B8);
    sample(16'h0000, 16'h1000, 16'h0000, 16'h0000);
    pins(16'h0000);
    rd(8'h01, 16'h0430);
    rd(8'h01, 16'h0400);
    // Latched warnings, unlatched over-limits active low
    wr(8'h0F, 16'hFFFF, 41);
    wr(8'h0D, 16'hFF00, 41);
    wr(8'h0E, 16'h0100, 41);
    wr(8'h10, 16'h0800, 41);
    wr(8'h11, 16'h0200, 41);
    wr(8'h12, 16'hFFFC, 41);
    wr(8'h13, 16'h0800, 41);
    sample(16'hFE00, 16'h0400, 16'h0300, 16'h0000);
    pins(16'h0002);
    rd(8'h01, 16'h6B60);
    sample(16'h0000, 16'h1000, 16'h0000, 16'h0000);
    pins(16'h0003);
    rd(8'h01, 16'h6820);
    rd(8'h01, 16'h0000);
    i_pmon_host_model.idle(2);
    conclude();
  end
endmodule : power_monitor_register_map_tb_top
